// ### oss_level_timer.sv
// Holds a flag once a level has stood for a number of ticks.
// Assumes tick_en is a one-cycle pulse from the divider in the top.
`timescale 1ns/1ps
module oss_level_timer import oss_pkg::*; (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst,
	// Time base and condition
	input  wire logic              tick_en,
	input  wire logic              above,
	input  wire logic [DATA_W-1:0] limit,
	// Result
	output logic                   hit_q
);

	logic [DATA_W-1:0] cnt_q;

	wire cnt_done = cnt_q >= limit;
	// Saturate so a long stand never wraps back under the limit
	wire cnt_step = tick_en && !cnt_done;

	always_ff @(posedge core_clk) begin
		if (rst || !above) begin
			cnt_q <= 16'h0000;
			hit_q <= 1'b0;
		end else begin
			if (cnt_step)
				cnt_q <= cnt_q + 16'h0001;
			hit_q <= cnt_done;
		end
	end

endmodule : oss_level_timer

// ### oss_load_model.sv
// Far side: a lamp on the open collector and a coil on the relay.
// Assumes terminal levels come straight from the selector, high = on.
`timescale 1ns/1ps
module oss_load_model (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst,
	// Terminals
	input  wire logic oc_in,
	input  wire logic relay_in,
	// Seen by the equipment
	output logic      lamp_q,
	output logic      coil_q
);
	// One sample a clock; contact bounce not modelled
	always_ff @(posedge core_clk) begin
		lamp_q <= rst ? 1'b0 : oc_in;
		coil_q <= rst ? 1'b0 : relay_in;
	end
endmodule : oss_load_model

// ### oss_output_select.sv
// Top of the output terminal signal selector: register port, status
// derivation and the two routed terminals (open collector and relay).
// Assumes drive and ext come from logic on core_clk; no pins are sampled.
`timescale 1ns/1ps

module oss_output_select import oss_pkg::*; #(
	parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT
) (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst,
	// Register port
	input  wire oss_reg_req_t      reg_req,
	output logic      [DATA_W-1:0] reg_rdata_q,
	// Drive state
	input  wire oss_drive_t        drive,
	input  wire oss_ext_t          ext,
	// Output terminals, high means conducting
	output logic                   oc_out_q,
	output logic                   relay_out_q,
	// Protection
	output logic                   thermal_trip_q
);

	// Settings
	logic [DATA_W-1:0] extended_param_gate_q;
	logic [DATA_W-1:0] speed_detect_level_q;
	logic [DATA_W-1:0] reverse_speed_detect_level_q;
	logic [DATA_W-1:0] current_detect_level_q;
	logic [DATA_W-1:0] current_detect_time_q;
	logic [DATA_W-1:0] regen_duty_limit_q;

	// Selections as held by the terminals
	logic [DATA_W-1:0] open_collector_output_select;
	logic [DATA_W-1:0] relay_output_select;

	// Derived state
	logic              drive_running_q;
	logic              dc_brake_q;
	logic              drive_ready_q;
	logic [SIG_N-1:0]  sig_q;
	logic [DATA_W-1:0] reg_rdata_d;
	logic [14:0]       tick_cnt_q;
	logic              tick_en_q;
	logic              current_level_detect;

	// Time base divider
	wire tick_wrap = tick_cnt_q == 15'(TICK_CYCLES - 1);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			tick_cnt_q <= 15'h0000;
			tick_en_q  <= 1'b0;
		end else begin
			tick_cnt_q <= tick_wrap ? 15'h0000 : tick_cnt_q + 15'h0001;
			tick_en_q  <= tick_wrap;
		end
	end

	// Address decode
	wire hit_oc    = reg_req.addr == ADDR_OC_SEL;
	wire hit_relay = reg_req.addr == ADDR_RELAY_SEL;
	wire hit_gate  = reg_req.addr == ADDR_GATE;
	wire hit_spd   = reg_req.addr == ADDR_SPD_LVL;
	wire hit_rev   = reg_req.addr == ADDR_REV_LVL;
	wire hit_clvl  = reg_req.addr == ADDR_CUR_LVL;
	wire hit_ctime = reg_req.addr == ADDR_CUR_TIME;
	wire hit_regen = reg_req.addr == ADDR_REGEN_LIM;

	wire gate_open = extended_param_gate_q == 16'h0000;
	wire wr_oc     = reg_req.wr && hit_oc && gate_open;
	wire wr_relay  = reg_req.wr && hit_relay && gate_open;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			extended_param_gate_q        <= GATE_RST;
			speed_detect_level_q         <= LVL_RST;
			reverse_speed_detect_level_q <= LVL_RST;
			current_detect_level_q       <= LVL_RST;
			current_detect_time_q        <= LVL_RST;
			regen_duty_limit_q           <= REGEN_LIM_RST;
		end else if (reg_req.wr) begin
			if (hit_gate)
				extended_param_gate_q <= reg_req.wdata;
			if (hit_spd)
				speed_detect_level_q <= reg_req.wdata;
			if (hit_rev)
				reverse_speed_detect_level_q <= reg_req.wdata;
			if (hit_clvl)
				current_detect_level_q <= reg_req.wdata;
			if (hit_ctime)
				current_detect_time_q <= reg_req.wdata;
			if (hit_regen)
				regen_duty_limit_q <= reg_req.wdata;
		end
	end

	// Running indication
	wire brake_start = drive.dc_brake && !dc_brake_q;
	wire run_start   = drive.start_on && drive.running;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			dc_brake_q      <= 1'b0;
			drive_running_q <= 1'b0;
			drive_ready_q   <= 1'b0;
		end else begin
			dc_brake_q <= drive.dc_brake;
			if (brake_start)
				drive_running_q <= 1'b0;
			else if (run_start)
				drive_running_q <= 1'b1;
			drive_ready_q <= drive.reset_done;
		end
	end

	wire speed_reached = drive.running && (drive.speed >= drive.set_speed);

	wire [DATA_W-1:0] spd_level = drive.reverse ? reverse_speed_detect_level_q
	                                            : speed_detect_level_q;
	wire speed_threshold_hit = drive.speed >= spd_level;

	wire stall_warning = drive.stall_active;

	wire regen_duty_prewarn = oss_pct_reached(drive.regen_duty, regen_duty_limit_q,
	                                          PCT_PREWARN);

	wire thermal_prewarn = oss_pct_reached(drive.thermal_acc, THERM_FULL, PCT_PREWARN);
	wire thermal_full    = oss_pct_reached(drive.thermal_acc, THERM_FULL, PCT_TRIP);

	wire pid_low_limit_flag  = drive.pid_feedback < drive.pid_low;
	wire pid_high_limit_flag = drive.pid_feedback > drive.pid_high;
	wire pid_forward_dir     = drive.pid_forward;

	wire brake_release_request = drive.brake_request;

	wire fan_fault = drive.fan_fault;

	wire heatsink_prewarn = oss_pct_reached(drive.heatsink_temp, drive.heatsink_trip,
	                                        PCT_PREWARN);

	wire preexcite_ready = drive.preexcite || drive_running_q;

	oss_level_timer u_cur_timer (
		.core_clk (core_clk),
		.rst      (rst),
		.tick_en  (tick_en_q),
		.above    (drive.current >= current_detect_level_q),
		.limit    (current_detect_time_q),
		.hit_q    (current_level_detect)
	);

	// Status vector, index order matches the code table
	wire [SIG_N-1:0] sig_d = {
		ext.fault_out,
		ext.alarm_out,
		ext.remote_out,
		ext.maint_timer,
		ext.current_avg_pulse,
		ext.fault_out3,
		ext.life_alarm,
		ext.power_pulse,
		ext.pid_sleep,
		ext.retry,
		ext.pid_dev_limit,
		ext.pid_active,
		ext.ready3,
		preexcite_ready,
		heatsink_prewarn,
		fan_fault,
		ext.brake_interlock,
		brake_release_request,
		pid_forward_dir,
		pid_high_limit_flag,
		pid_low_limit_flag,
		ext.zero_current,
		current_level_detect,
		drive_ready_q,
		thermal_prewarn,
		regen_duty_prewarn,
		speed_threshold_hit,
		stall_warning,
		speed_reached,
		drive_running_q
	};

	// Thermal trip holds until the fault reset; a new trip wins over reset
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sig_q          <= '0;
			thermal_trip_q <= 1'b0;
		end else begin
			sig_q <= sig_d;
			if (thermal_full)
				thermal_trip_q <= 1'b1;
			else if (drive.fault_reset)
				thermal_trip_q <= 1'b0;
		end
	end

	oss_terminal #(
		.RELAY    (1'b0),
		.RST_CODE (SEL_OC_RST)
	) u_oc (
		.core_clk (core_clk),
		.rst      (rst),
		.wr_en    (wr_oc),
		.wr_data  (reg_req.wdata),
		.sig_vec  (sig_q),
		.sel_q    (open_collector_output_select),
		.term_q   (oc_out_q)
	);

	oss_terminal #(
		.RELAY    (1'b1),
		.RST_CODE (SEL_RELAY_RST)
	) u_relay (
		.core_clk (core_clk),
		.rst      (rst),
		.wr_en    (wr_relay),
		.wr_data  (reg_req.wdata),
		.sig_vec  (sig_q),
		.sel_q    (relay_output_select),
		.term_q   (relay_out_q)
	);

	// Read data; unmapped addresses read zero
	always_comb begin
		if (!reg_req.rd)
			reg_rdata_d = 16'h0000;
		else if (hit_oc)
			reg_rdata_d = open_collector_output_select;
		else if (hit_relay)
			reg_rdata_d = relay_output_select;
		else if (hit_gate)
			reg_rdata_d = extended_param_gate_q;
		else if (hit_spd)
			reg_rdata_d = speed_detect_level_q;
		else if (hit_rev)
			reg_rdata_d = reverse_speed_detect_level_q;
		else if (hit_clvl)
			reg_rdata_d = current_detect_level_q;
		else if (hit_ctime)
			reg_rdata_d = current_detect_time_q;
		else if (hit_regen)
			reg_rdata_d = regen_duty_limit_q;
		else if (reg_req.addr == ADDR_SIG_LO)
			reg_rdata_d = sig_q[15:0];
		else if (reg_req.addr == ADDR_SIG_HI)
			reg_rdata_d = {2'b00, sig_q[SIG_N-1:16]};
		else if (reg_req.addr == ADDR_TERM)
			reg_rdata_d = {13'h0000, thermal_trip_q, relay_out_q, oc_out_q};
		else
			reg_rdata_d = 16'h0000;
	end

	// Read data only stands the cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (rst)
			reg_rdata_q <= 16'h0000;
		else
			reg_rdata_q <= reg_rdata_d;
	end

endmodule : oss_output_select

// ### oss_output_select_asserts.sv
// Port-level properties of the output terminal selector.
// Assumes it is bound to oss_output_select and sees only its ports.
`timescale 1ns/1ps
module oss_output_select_chk import oss_pkg::*; #(
	parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT
) (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst,
	// Register port
	input  wire oss_reg_req_t      reg_req,
	input  wire logic [DATA_W-1:0] reg_rdata_q,
	// Drive state
	input  wire oss_drive_t        drive,
	input  wire oss_ext_t          ext,
	// Terminals
	input  wire logic              oc_out_q,
	input  wire logic              relay_out_q,
	input  wire logic              thermal_trip_q
);
	logic              rd_oc_q;
	logic              rd_rl_q;
	logic              oc_valid_q;
	logic              oc_touch_q;
	logic              rl_def_q;
	logic [DATA_W-1:0] oc_seen_q;
	logic [DATA_W-1:0] gate_q;
	logic [1:0]        settle_q;
	wire               wr_oc   = reg_req.wr && reg_req.addr == ADDR_OC_SEL;
	wire               wr_open = wr_oc && gate_q == 16'h0000;
	wire               oc_fix  = oc_valid_q && !oc_touch_q;

	// Last read-back of the oc select, voided by any write that could land
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rd_oc_q    <= 1'b0;
			rd_rl_q    <= 1'b0;
			oc_valid_q <= 1'b0;
			oc_touch_q <= 1'b0;
			rl_def_q   <= 1'b1;
			oc_seen_q  <= 16'h0000;
			gate_q     <= 16'h0000;
			settle_q   <= 2'h0;
		end else begin
			rd_oc_q    <= reg_req.rd && reg_req.addr == ADDR_OC_SEL;
			rd_rl_q    <= reg_req.rd && reg_req.addr == ADDR_RELAY_SEL;
			oc_valid_q <= oc_valid_q || rd_oc_q;
			oc_touch_q <= wr_open || (oc_touch_q && !rd_oc_q);
			rl_def_q   <= rl_def_q && !(reg_req.wr && reg_req.addr == ADDR_RELAY_SEL);
			oc_seen_q  <= rd_oc_q ? reg_rdata_q : oc_seen_q;
			gate_q     <= (reg_req.wr && reg_req.addr == ADDR_GATE) ? reg_req.wdata : gate_q;
			settle_q   <= (settle_q == 2'h3) ? settle_q : settle_q + 2'h1;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	property p_sel_persist;
		rd_oc_q && oc_fix |-> reg_rdata_q == oc_seen_q;
	endproperty
	a_sel_persist: assert property (p_sel_persist)
		else $error("oc select changed without an open write");
	property p_none_off;
		oc_fix && oc_seen_q == CODE_NONE |-> !oc_out_q;
	endproperty
	a_none_off: assert property (p_none_off)
		else $error("oc terminal on with no function selected");
	property p_fan_pos;
		oc_fix && oc_seen_q == 16'h0019 |-> oc_out_q == $past(drive.fan_fault, 2);
	endproperty
	a_fan_pos: assert property (p_fan_pos)
		else $error("oc terminal does not follow fan fault");
	property p_fan_neg;
		oc_fix && oc_seen_q == 16'h007D |-> oc_out_q != $past(drive.fan_fault, 2);
	endproperty
	a_fan_neg: assert property (p_fan_neg)
		else $error("inverted fan fault wrong on oc terminal");
	property p_relay_def;
		settle_q == 2'h3 && rl_def_q |-> relay_out_q == $past(ext.fault_out, 2);
	endproperty
	a_relay_def: assert property (p_relay_def)
		else $error("relay does not carry fault output after reset");
	property p_relay_bar;
		rd_rl_q |-> reg_rdata_q != CODE_BAR_A && reg_rdata_q != CODE_BAR_B;
	endproperty
	a_relay_bar: assert property (p_relay_bar)
		else $error("relay select holds a barred code");
	property p_code_range;
		rd_oc_q || rd_rl_q |-> reg_rdata_q <= CODE_NEGMAX || reg_rdata_q == CODE_NONE;
	endproperty
	a_code_range: assert property (p_code_range)
		else $error("select holds a code out of range");
	property p_trip_set;
		drive.thermal_acc >= THERM_FULL |-> ##[1:3] thermal_trip_q;
	endproperty
	a_trip_set: assert property (p_trip_set)
		else $error("thermal trip missing at full scale");
	property p_trip_hold;
		$fell(thermal_trip_q) |-> $past(drive.fault_reset) || $past(drive.fault_reset, 2)
			|| $past(drive.fault_reset, 3);
	endproperty
	a_trip_hold: assert property (p_trip_hold)
		else $error("thermal trip cleared without fault reset");

	c_readback: cover property (rd_oc_q && oc_fix);
	c_trip: cover property ($rose(thermal_trip_q));
	c_locked: cover property (wr_oc && gate_q != 16'h0000);
endmodule : oss_output_select_chk

bind oss_output_select oss_output_select_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
	.core_clk(core_clk), .rst(rst), .reg_req(reg_req), .reg_rdata_q(reg_rdata_q),
	.drive(drive), .ext(ext), .oc_out_q(oc_out_q), .relay_out_q(relay_out_q),
	.thermal_trip_q(thermal_trip_q));

// ### oss_pkg.sv
// Constants, codes and carriers for the output terminal signal selector.
// Assumes one 20 MHz clock and a plain strobe-style register port.
package oss_pkg;

	localparam int unsigned DATA_W = 16;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned SIG_N  = 30;

	// Register addresses
	localparam logic [ADDR_W-1:0] ADDR_OC_SEL    = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_RELAY_SEL = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_GATE      = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_SPD_LVL   = 4'h3;
	localparam logic [ADDR_W-1:0] ADDR_REV_LVL   = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_CUR_LVL   = 4'h5;
	localparam logic [ADDR_W-1:0] ADDR_CUR_TIME  = 4'h6;
	localparam logic [ADDR_W-1:0] ADDR_REGEN_LIM = 4'h7;
	localparam logic [ADDR_W-1:0] ADDR_SIG_LO    = 4'h8;
	localparam logic [ADDR_W-1:0] ADDR_SIG_HI    = 4'h9;
	localparam logic [ADDR_W-1:0] ADDR_TERM      = 4'hA;

	// Reset values
	localparam logic [DATA_W-1:0] SEL_OC_RST    = 16'h0000;
	localparam logic [DATA_W-1:0] SEL_RELAY_RST = 16'h0063;
	localparam logic [DATA_W-1:0] GATE_RST      = 16'h0000;
	localparam logic [DATA_W-1:0] LVL_RST       = 16'h0000;
	localparam logic [DATA_W-1:0] REGEN_LIM_RST = 16'h0064;

	// Selection codes
	localparam logic [DATA_W-1:0] CODE_NONE   = 16'h270F;
	localparam logic [DATA_W-1:0] CODE_NEG    = 16'h0064;
	localparam logic [DATA_W-1:0] CODE_NEGMAX = 16'h00C7;
	localparam logic [DATA_W-1:0] CODE_BAR_A  = 16'h005D;
	localparam logic [DATA_W-1:0] CODE_BAR_B  = 16'h00C0;

	// Percent thresholds; thermal accumulator full scale is 100.00 %
	localparam logic [6:0]        PCT_PREWARN = 7'h55;
	localparam logic [6:0]        PCT_TRIP    = 7'h64;
	localparam logic [DATA_W-1:0] THERM_FULL  = 16'h2710;

	// Timing: current detect time counts in 1 ms ticks
	localparam int unsigned CLK_PERIOD_NS    = 50;
	localparam int unsigned TICK_PERIOD_NS   = 1000000;
	localparam int unsigned TICK_CYCLES_DFLT = TICK_PERIOD_NS / CLK_PERIOD_NS;

	typedef struct packed {
		logic                  wr;
		logic                  rd;
		logic [ADDR_W-1:0]     addr;
		logic [DATA_W-1:0]     wdata;
	} oss_reg_req_t;

	typedef struct packed {
		logic                  start_on;
		logic                  running;
		logic                  dc_brake;
		logic                  reverse;
		logic                  reset_done;
		logic                  preexcite;
		logic                  fault_reset;
		logic                  stall_active;
		logic                  pid_forward;
		logic                  brake_request;
		logic                  fan_fault;
		logic [DATA_W-1:0]     speed;
		logic [DATA_W-1:0]     set_speed;
		logic [DATA_W-1:0]     current;
		logic [DATA_W-1:0]     regen_duty;
		logic [DATA_W-1:0]     thermal_acc;
		logic [DATA_W-1:0]     heatsink_temp;
		logic [DATA_W-1:0]     heatsink_trip;
		logic [DATA_W-1:0]     pid_feedback;
		logic [DATA_W-1:0]     pid_low;
		logic [DATA_W-1:0]     pid_high;
	} oss_drive_t;

	typedef struct packed {
		logic zero_current;
		logic brake_interlock;
		logic ready3;
		logic pid_active;
		logic pid_dev_limit;
		logic retry;
		logic pid_sleep;
		logic power_pulse;
		logic life_alarm;
		logic fault_out3;
		logic current_avg_pulse;
		logic maint_timer;
		logic remote_out;
		logic alarm_out;
		logic fault_out;
	} oss_ext_t;

	// Bit 5 set when the base code names a signal; bits 4:0 its index
	function automatic logic [5:0] oss_code_index(input logic [DATA_W-1:0] base);
		case (base)
			16'h0000: return 6'h20;
			16'h0001: return 6'h21;
			16'h0003: return 6'h22;
			16'h0004: return 6'h23;
			16'h0007: return 6'h24;
			16'h0008: return 6'h25;
			16'h000B: return 6'h26;
			16'h000C: return 6'h27;
			16'h000D: return 6'h28;
			16'h000E: return 6'h29;
			16'h000F: return 6'h2A;
			16'h0010: return 6'h2B;
			16'h0014: return 6'h2C;
			16'h0015: return 6'h2D;
			16'h0019: return 6'h2E;
			16'h001A: return 6'h2F;
			16'h0021: return 6'h30;
			16'h0025: return 6'h31;
			16'h002F: return 6'h32;
			16'h0030: return 6'h33;
			16'h0040: return 6'h34;
			16'h0046: return 6'h35;
			16'h004F: return 6'h36;
			16'h005A: return 6'h37;
			16'h005B: return 6'h38;
			16'h005D: return 6'h39;
			16'h005F: return 6'h3A;
			16'h0060: return 6'h3B;
			16'h0062: return 6'h3C;
			16'h0063: return 6'h3D;
			default:  return 6'h00;
		endcase
	endfunction : oss_code_index

	function automatic logic oss_code_neg(input logic [DATA_W-1:0] code);
		return (code >= CODE_NEG) && (code <= CODE_NEGMAX);
	endfunction : oss_code_neg

	function automatic logic [DATA_W-1:0] oss_code_base(input logic [DATA_W-1:0] code);
		return oss_code_neg(code) ? code - CODE_NEG : code;
	endfunction : oss_code_base

	function automatic logic oss_code_ok(input logic [DATA_W-1:0] code, input logic relay);
		if (code == CODE_NONE)
			return 1'b1;
		if (relay && (code == CODE_BAR_A || code == CODE_BAR_B))
			return 1'b0;
		if (code > CODE_NEGMAX)
			return 1'b0;
		return oss_code_index(oss_code_base(code)) >= 6'h20;
	endfunction : oss_code_ok

	// True when val reaches pct percent of lim
	function automatic logic oss_pct_reached(input logic [DATA_W-1:0] val,
			input logic [DATA_W-1:0] lim, input logic [6:0] pct);
		return (24'(val) * 24'h000064) >= (24'(lim) * 24'(pct));
	endfunction : oss_pct_reached

endpackage : oss_pkg

// ### oss_terminal.sv
// One output terminal: selection setting, code check, routing and polarity.
// Assumes the status vector is already registered on core_clk.
`timescale 1ns/1ps
module oss_terminal import oss_pkg::*; #(
	parameter logic              RELAY    = 1'b0,
	parameter logic [DATA_W-1:0] RST_CODE = SEL_OC_RST
) (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst,
	// Setting write
	input  wire logic              wr_en,
	input  wire logic [DATA_W-1:0] wr_data,
	// Status in, terminal out
	input  wire logic [SIG_N-1:0]  sig_vec,
	output logic      [DATA_W-1:0] sel_q,
	output logic                   term_q
);

	wire [5:0] hit     = oss_code_index(oss_code_base(sel_q));
	wire       idle    = (sel_q == CODE_NONE) || !hit[5];
	wire       neg     = oss_code_neg(sel_q);
	wire       pick    = sig_vec[hit[4:0]];
	wire       wr_ok   = wr_en && oss_code_ok(wr_data, RELAY);
	wire       term_d  = idle ? 1'b0 : (pick ^ neg);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			sel_q  <= RST_CODE;
			term_q <= 1'b0;
		end else begin
			if (wr_ok)
				sel_q <= wr_data;
			term_q <= term_d;
		end
	end

endmodule : oss_terminal

// ### tb_top.sv
// Self-checking bench for the output terminal selector.
// Assumes a 20 MHz core_clk; reads are compared by a monitor process.
`timescale 1ns/1ps
module tb_top import oss_pkg::*; ;
	localparam int unsigned TICKS = 4;
	logic              core_clk;
	logic              rst;
	oss_reg_req_t      req;
	logic [DATA_W-1:0] rdata;
	oss_drive_t        drv;
	oss_ext_t          ext;
	logic              oc_out;
	logic              relay_out;
	logic              trip;
	logic              lamp;
	logic              coil;
	logic [DATA_W-1:0] exp_q[$];
	logic [DATA_W-1:0] v;
	logic [DATA_W-1:0] oc_exp;
	logic [DATA_W-1:0] rl_exp;
	logic              s;
	logic              pend;
	int                error_cnt;
	int                cmp_count;
	int                seed;
	int                base_l[30] = '{0, 1, 3, 4, 7, 8, 11, 12, 13, 14, 15, 16, 20, 21, 25,
		26, 33, 37, 47, 48, 64, 70, 79, 90, 91, 93, 95, 96, 98, 99};
	int                rt_l[12] = '{3, 4, 7, 8, 11, 14, 15, 16, 20, 25, 26, 99};

	oss_output_select #(.TICK_CYCLES(TICKS)) dut_u (.core_clk(core_clk), .rst(rst),
		.reg_req(req), .reg_rdata_q(rdata), .drive(drv), .ext(ext), .oc_out_q(oc_out),
		.relay_out_q(relay_out), .thermal_trip_q(trip));
	oss_load_model load_u (.core_clk(core_clk), .rst(rst), .oc_in(oc_out),
		.relay_in(relay_out), .lamp_q(lamp), .coil_q(coil));

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	task automatic finish_test();
		if (exp_q.size() != 0) error_cnt++;
		$display("compares %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge core_clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge core_clk);
		req.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		exp_q.push_back(e);
		@(posedge core_clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge core_clk);
		req.rd <= 1'b0;
	endtask : rd

	function automatic logic code_ok(input int c, input logic relay);
		if (c == 9999) return 1'b1;
		if (c > 199 || (relay && (c == 93 || c == 192))) return 1'b0;
		foreach (base_l[i]) if (base_l[i] == c % 100) return 1'b1;
		return 1'b0;
	endfunction : code_ok

	function automatic logic sig_of(input int b);
		case (b)
			3: return drv.stall_active;
			4: return drv.speed >= (drv.reverse ? 16'h2000 : 16'h1000);
			7: return drv.regen_duty >= 16'h0055;
			8: return drv.thermal_acc >= 16'h2134;
			11: return drv.reset_done;
			14: return drv.pid_feedback < drv.pid_low;
			15: return drv.pid_feedback > drv.pid_high;
			16: return drv.pid_forward;
			20: return drv.brake_request;
			25: return drv.fan_fault;
			26: return 32'(drv.heatsink_temp) * 32'h64 >= 32'(drv.heatsink_trip) * 32'h55;
			default: return ext.fault_out;
		endcase
	endfunction : sig_of

	// Flags and levels spread around each threshold; trip level never reached
	task automatic shake();
		@(posedge core_clk);
		drv[$bits(oss_drive_t)-1 -: 11] <= 11'($random(seed));
		drv.speed <= 16'($random(seed)) & 16'h3FFF;
		drv.regen_duty <= 16'($unsigned($random(seed)) % 170);
		drv.thermal_acc <= 16'($unsigned($random(seed)) % 10000);
		drv.heatsink_temp <= 16'($unsigned($random(seed)) % 200);
		drv.heatsink_trip <= 16'($unsigned($random(seed)) % 100 + 100);
		drv.pid_feedback <= 16'($random(seed)) & 16'h00FF;
		drv.pid_low <= 16'($random(seed)) & 16'h00FF;
		drv.pid_high <= 16'($random(seed)) & 16'h00FF;
		ext <= oss_ext_t'(15'($random(seed)));
	endtask : shake

	always @(posedge core_clk) begin : mon
		logic [DATA_W-1:0] e;
		if (pend) begin
			e = exp_q.pop_front();
			cmp_count++;
			if (rdata !== e) begin
				error_cnt++;
				$display("[ERR] t=%0t got=%h exp=%h", $time, rdata, e);
			end
		end
		pend = req.rd;
	end

	initial begin
		repeat (60000) @(posedge core_clk);
		error_cnt++;
		$display("[ERR] t=%0t timeout got=%h exp=%h", $time, 1'b0, 1'b1);
		finish_test();
	end

	initial begin
		seed = 32'h28e559fe;
		error_cnt = 0;
		cmp_count = 0;
		pend = 1'b0;
		req = '0;
		drv = '0;
		ext = '0;
		rst = 1'b1;
		tick(3);
		rst <= 1'b0;
		repeat (4) shake();
		rd(ADDR_OC_SEL, SEL_OC_RST);
		rd(ADDR_RELAY_SEL, SEL_RELAY_RST);
		rd(ADDR_REGEN_LIM, REGEN_LIM_RST);
		$display("reset values done");
		oc_exp = SEL_OC_RST;
		rl_exp = SEL_RELAY_RST;
		for (int c = 0; c <= 201; c++) begin
			v = (c == 201) ? CODE_NONE : 16'(c);
			wr(ADDR_OC_SEL, v);
			if (code_ok(int'(v), 1'b0)) oc_exp = v;
			rd(ADDR_OC_SEL, oc_exp);
			wr(ADDR_RELAY_SEL, v);
			if (code_ok(int'(v), 1'b1)) rl_exp = v;
			rd(ADDR_RELAY_SEL, rl_exp);
		end
		$display("code acceptance done");
		wr(ADDR_GATE, 16'h0001);
		wr(ADDR_OC_SEL, 16'h0019);
		wr(ADDR_RELAY_SEL, 16'h0019);
		rd(ADDR_OC_SEL, CODE_NONE);
		rd(ADDR_RELAY_SEL, CODE_NONE);
		wr(ADDR_GATE, 16'h0000);
		$display("write lock done");
		wr(ADDR_SPD_LVL, 16'h1000);
		wr(ADDR_REV_LVL, 16'h2000);
		for (int r = 0; r < 8; r++) begin
			shake();
			foreach (rt_l[i]) for (int n = 0; n < 2; n++) begin
				v = 16'(rt_l[i] + 100 * n);
				wr(ADDR_OC_SEL, v);
				wr(ADDR_RELAY_SEL, v);
				rd(ADDR_OC_SEL, v);
				tick(2);
				s = sig_of(rt_l[i]) ^ n[0];
				rd(ADDR_TERM, {14'h0000, s, s});
			end
		end
		$display("routing and polarity done");
		@(posedge core_clk);
		drv <= '0;
		ext <= '0;
		wr(ADDR_OC_SEL, 16'h0000);
		// Clear any running state left by the random phase
		drv.dc_brake <= 1'b1;
		wr(ADDR_RELAY_SEL, 16'h0001);
		drv.dc_brake <= 1'b0;
		rd(ADDR_TERM, 16'h0000);
		drv.start_on <= 1'b1;
		drv.running <= 1'b1;
		drv.speed <= 16'h0100;
		drv.set_speed <= 16'h0100;
		tick(4);
		rd(ADDR_TERM, 16'h0003);
		cmp_count++;
		if ({coil, lamp} !== 2'b11) begin
			error_cnt++;
			$display("[ERR] t=%0t load got=%h exp=%h", $time, {coil, lamp}, 2'b11);
		end
		// Running, speed reached, current at zero time, heatsink at zero trip
		rd(ADDR_SIG_LO, 16'h8083);
		rd(ADDR_SIG_HI, 16'h0001);
		drv.start_on <= 1'b0;
		drv.set_speed <= 16'h0101;
		tick(4);
		rd(ADDR_TERM, 16'h0001);
		drv.dc_brake <= 1'b1;
		tick(4);
		rd(ADDR_TERM, 16'h0000);
		$display("running done");
		wr(ADDR_CUR_LVL, 16'h0100);
		wr(ADDR_CUR_TIME, 16'h0002);
		wr(ADDR_OC_SEL, 16'h000C);
		drv.current <= 16'h0100;
		tick(2);
		rd(ADDR_TERM, 16'h0000);
		tick(4 * TICKS);
		rd(ADDR_TERM, 16'h0001);
		drv.current <= 16'h00FF;
		tick(4);
		rd(ADDR_TERM, 16'h0000);
		$display("current detect done");
		wr(ADDR_OC_SEL, 16'h0008);
		drv.thermal_acc <= 16'h2134;
		tick(3);
		rd(ADDR_TERM, 16'h0001);
		drv.thermal_acc <= THERM_FULL;
		tick(3);
		drv.thermal_acc <= 16'h0000;
		tick(3);
		rd(ADDR_TERM, 16'h0004);
		drv.fault_reset <= 1'b1;
		tick(1);
		drv.fault_reset <= 1'b0;
		tick(3);
		rd(ADDR_TERM, 16'h0000);
		$display("thermal done");
		wr(4'hF, 16'h1234);
		rd(4'hF, 16'h0000);
		wr(ADDR_GATE, 16'h0005);
		rst <= 1'b1;
		tick(3);
		rst <= 1'b0;
		rd(ADDR_OC_SEL, SEL_OC_RST);
		rd(ADDR_GATE, GATE_RST);
		rd(ADDR_RELAY_SEL, SEL_RELAY_RST);
		tick(3);
		$display("second reset done");
		finish_test();
	end
endmodule : tb_top
